// File: design/xcvr_mon_pkg.sv
package xcvr_mon_pkg;

    // ==========================================================
    // Register offsets.
    localparam logic [7:0] OFS_CRIT_A   = 8'h00;
    localparam logic [7:0] OFS_CRIT_B   = 8'h01;
    localparam logic [7:0] OFS_ADV_A    = 8'h02;
    localparam logic [7:0] OFS_ADV_B    = 8'h03;
    localparam logic [7:0] OFS_SHIFT    = 8'h04;
    localparam logic [7:0] OFS_INDEX    = 8'h05;
    localparam logic [7:0] OFS_PINS     = 8'h06;
    localparam logic [7:0] OFS_CFG      = 8'h07;
    localparam logic [7:0] OFS_HOUR_HI  = 8'h08;
    localparam logic [7:0] OFS_HOUR_LO  = 8'h09;
    localparam logic [7:0] OFS_STORE    = 8'h10;

    // ==========================================================
    // Field positions and reset values.
    localparam int         PIN_TXOFF    = 3;
    localparam int         OD_LOS       = 0;
    localparam int         OD_RATE      = 1;
    localparam int         OD_FLT       = 2;
    localparam int         CTL_RATE_BIT = 0;
    localparam int         CFG_WRST_BIT = 0;
    localparam logic [7:0] SHIFT_RST    = 8'h00;
    localparam logic [2:0] OD_OFF       = 3'h7;

    // ==========================================================
    // Table layout and averaging.
    localparam int              IDX_TOP    = 63;
    localparam int              AVG_SHIFT  = 4;
    localparam logic [3:0]      AVG_LAST   = 4'hF;
    localparam logic [3:0][7:0] TABLE_BASE = {8'hC0, 8'h80, 8'h40, 8'h00};

    // ==========================================================
    // Hour meter timing.
    localparam longint unsigned CLK_HZ        = 200_000_000;
    localparam longint unsigned SEC_PER_HOUR  = 3600;
    localparam longint unsigned UNIT_HOURS    = 10;
    localparam longint unsigned UNIT_CYC_DEF  = UNIT_HOURS * SEC_PER_HOUR * CLK_HZ;
    localparam int              PRE_W         = 44;

    typedef struct packed {
        logic [7:0] crit_a;
        logic [1:0] crit_b;
        logic [7:0] adv_a;
        logic [1:0] adv_b;
    } threshold_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_t;

    typedef logic [3:0][7:0] quad_byte_t;
    typedef logic [3:0][8:0] quad_sum_t;
    typedef logic [7:0][7:0] store_t;

endpackage

// File: design/xcvr_monitor.sv
`timescale 1ns/10ps
// What this block does
// - Each new average gives index = floor(average / 2) + range shift.
// - Four table addresses are index plus bases 00h, 40h, 80h, C0h.
// - The index in use is always readable in the index readback register.
// - Index clamps to 63 above and 0 below, never wrapping.
// - Each selected table entry is added to its parameter's nominal value.
// - Twenty threshold conditions set warning or alarm status bits.
// - Alarm bits: temp, supply, bias, tx power high/low; rx power bits 7/6.
// - Warning bits use the same placement as alarm bits.
// - A condition becoming true sets its status bit; no mask exists.
// - A set bit stays until its register is read, power cycles, warm reset, or toggle.
// - Transmit-off asserted leaves measuring and event reporting untouched.
// - Transmit-off deassertion clears all status registers.
// - Loss, rate and fault pins are open-drain; status shows pin levels.
// - Warm reset releases fault and loss, restores defaults, aborts conversion.
// - Hour meter steps mid interval; first step five hours after power-on.
// - Hour count accumulates while powered and lives in nonvolatile storage.
// - Result is a 15-bit count of ten-hour units plus corruption flag.
// - Multiple coded copies are kept; unrecoverable data sets the flag.
// - Hour registers are reachable only with a valid vendor password.
// - Writing zero to all eight store bytes restarts the count at zero.
// - Sixteen consecutive temperature samples are averaged.
// - Index changes only past the midpoint of the adjacent entry.
module xcvr_monitor
    import xcvr_mon_pkg::*;
#(
    parameter longint unsigned UNIT_CYCLES = UNIT_CYC_DEF
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire reg_req_t          reg_req_i,
    output logic [7:0]             reg_rdata_o,
    input  wire logic              temp_valid_i,
    input  wire logic signed [7:0] temp_sample_i,
    input  wire quad_byte_t        table_entry_i,
    input  wire quad_byte_t        nominal_i,
    output quad_byte_t             table_addr_o,
    output quad_sum_t              setpoint_o,
    output logic [5:0]             table_index_readback_o,
    output logic                   conv_abort_o,
    input  wire threshold_t        threshold_i,
    input  wire logic              transmit_off_input_i,
    input  wire logic              receive_loss_req_i,
    input  wire logic              transmit_fault_req_i,
    input  wire logic [2:0]        od_pin_i,
    output logic [2:0]             od_out_o,
    output logic [2:0]             od_oe_n_o,
    input  wire logic              password_ok_i,
    input  wire store_t            nvm_image_i,
    output store_t                 nvm_image_o,
    output logic                   nvm_write_o
);

    localparam logic [PRE_W-1:0] UNIT_LAST = PRE_W'(UNIT_CYCLES - 1);
    localparam logic [PRE_W-1:0] HALF_LAST = PRE_W'(UNIT_CYCLES / 2 - 1);
    if (UNIT_CYCLES < 2 || UNIT_CYCLES >= (64'h1 << PRE_W)) begin : g_bad_unit
        $error("UNIT_CYCLES out of range");
    end

    // ==========================================================
    // Reset, warm reset and pin synchronisers.
    logic        warm_reg;
    logic        rrst;
    logic [3:0]  sync1_reg;
    logic [3:0]  sync2_reg;
    logic        txoff_prev_reg;
    logic        txoff_fall;
    logic        load_reg;

    assign rrst       = rst_i | warm_reg;
    assign txoff_fall = txoff_prev_reg & ~sync2_reg[PIN_TXOFF];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            warm_reg <= 1'b0;
        end else begin
            warm_reg <= reg_req_i.wr && reg_req_i.addr == OFS_CFG
                        && reg_req_i.wdata[CFG_WRST_BIT];
        end
        if (rrst) begin
            sync1_reg      <= 4'h0;
            sync2_reg      <= 4'h0;
            txoff_prev_reg <= 1'b0;
        end else begin
            sync1_reg      <= {transmit_off_input_i, od_pin_i};
            sync2_reg      <= sync1_reg;
            txoff_prev_reg <= sync2_reg[PIN_TXOFF];
        end
    end

    assign conv_abort_o = warm_reg;

    // ==========================================================
    // Temperature averaging and table indexing.
    logic signed [11:0] acc_reg, acc_next;
    logic [3:0]         cnt_reg, cnt_next;
    logic signed [7:0]  avg_reg, avg_next;
    logic               done_reg, done_next;
    logic [5:0]         idx_reg, idx_next;
    logic               idx_ok_reg, idx_ok_next;
    logic [7:0]         shift_reg;
    quad_byte_t         addr_reg, addr_next;
    quad_sum_t          setp_reg, setp_next;
    logic signed [10:0] rel, half, cur2;
    logic               move;

    always_comb begin
        acc_next  = acc_reg;
        cnt_next  = cnt_reg;
        avg_next  = avg_reg;
        done_next = 1'b0;
        if (temp_valid_i) begin
            cnt_next = cnt_reg + 4'h1;
            acc_next = acc_reg + 12'(temp_sample_i);
            if (cnt_reg == AVG_LAST) begin
                acc_next  = 12'sh000;
                avg_next  = 8'((acc_reg + 12'(temp_sample_i)) >>> AVG_SHIFT);
                done_next = 1'b1;
            end
        end
        rel  = 11'(avg_reg) + $signed({2'h0, shift_reg, 1'b0});
        half = rel >>> 1;
        cur2 = $signed({4'h0, idx_reg, 1'b0});
        move = !idx_ok_reg || rel >= cur2 + 11'sh003 || rel <= cur2 - 11'sh002;
        idx_next    = idx_reg;
        idx_ok_next = idx_ok_reg;
        if (done_reg && move) begin
            idx_ok_next = 1'b1;
            if (half < 0) begin
                idx_next = 6'h00;
            end else if (half > IDX_TOP) begin
                idx_next = 6'(IDX_TOP);
            end else begin
                idx_next = half[5:0];
            end
        end
        for (int k = 0; k < 4; k++) begin
            addr_next[k] = TABLE_BASE[k] + {2'h0, idx_reg};
            setp_next[k] = {1'b0, nominal_i[k]} + {table_entry_i[k][7], table_entry_i[k]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rrst) begin
            acc_reg    <= 12'sh000;
            cnt_reg    <= 4'h0;
            avg_reg    <= 8'sh00;
            done_reg   <= 1'b0;
            idx_reg    <= 6'h00;
            idx_ok_reg <= 1'b0;
            addr_reg   <= TABLE_BASE;
            setp_reg   <= '0;
        end else begin
            acc_reg    <= acc_next;
            cnt_reg    <= cnt_next;
            avg_reg    <= avg_next;
            done_reg   <= done_next;
            idx_reg    <= idx_next;
            idx_ok_reg <= idx_ok_next;
            addr_reg   <= addr_next;
            setp_reg   <= setp_next;
        end
    end

    assign table_addr_o           = addr_reg;
    assign setpoint_o             = setp_reg;
    assign table_index_readback_o = idx_reg;

    // ==========================================================
    // Sticky alarm and warning flags.
    threshold_t  cond_prev_reg;
    threshold_t  flags_reg, flags_next;
    logic [19:0] rise, clr;
    logic        rd_hit;
    assign rd_hit = reg_req_i.rd;

    always_comb begin
        rise = threshold_i & ~cond_prev_reg;
        clr  = {20{txoff_fall}};
        clr[19:12] |= {8{rd_hit && reg_req_i.addr == OFS_CRIT_A}};
        clr[11:10] |= {2{rd_hit && reg_req_i.addr == OFS_CRIT_B}};
        clr[9:2]   |= {8{rd_hit && reg_req_i.addr == OFS_ADV_A}};
        clr[1:0]   |= {2{rd_hit && reg_req_i.addr == OFS_ADV_B}};
        flags_next = (flags_reg & ~clr) | rise;
    end

    always_ff @(posedge clk_i) begin
        if (rrst) begin
            cond_prev_reg <= '0;
            flags_reg     <= '0;
        end else begin
            cond_prev_reg <= threshold_i;
            flags_reg     <= flags_next;
        end
    end

    // ==========================================================
    // Hour meter, control pins and register access.
    store_t             store_reg, store_next;
    logic [3:0][15:0]   word;
    logic [3:0]         valid;
    logic [14:0]        hour_cnt, hour_inc;
    logic               corrupt;
    logic [PRE_W-1:0]   pre_reg, pre_next;
    logic               step, st_wr, nvw_next, nvw_reg;
    logic [2:0]         od_reg, od_next;
    logic               rate_reg, rate_next;
    logic [7:0]         shift_next, rdata_reg, rdata_next, rsel;

    assign word = store_reg;
    always_comb begin
        hour_cnt = 15'h0000;
        corrupt  = 1'b1;
        for (int k = 0; k < 4; k++) begin
            valid[k] = word[k][15] == ^word[k][14:0];
        end
        for (int k = 3; k >= 0; k--) begin
            for (int j = 0; j < 4; j++) begin
                if (j != k && valid[k] && valid[j] && word[k] == word[j]) begin
                    hour_cnt = word[k][14:0];
                    corrupt  = 1'b0;
                end
            end
        end
        hour_inc = hour_cnt + 15'h0001;
        step     = pre_reg == HALF_LAST && !corrupt;
        pre_next = (pre_reg == UNIT_LAST) ? '0 : pre_reg + PRE_W'(1);
        st_wr    = reg_req_i.wr && password_ok_i && reg_req_i.addr[7:3] == OFS_STORE[7:3];
        store_next = store_reg;
        nvw_next   = 1'b0;
        if (load_reg) begin
            store_next = nvm_image_i;
        end else if (st_wr) begin
            store_next[reg_req_i.addr[2:0]] = reg_req_i.wdata;
            nvw_next = 1'b1;
        end else if (step) begin
            store_next = {4{^hour_inc, hour_inc}};
            nvw_next   = 1'b1;
        end
        od_next = od_reg;
        od_next[OD_LOS]  = ~receive_loss_req_i;
        od_next[OD_RATE] = ~rate_reg;
        if (transmit_fault_req_i) begin
            od_next[OD_FLT] = 1'b0;
        end else if (txoff_fall) begin
            od_next[OD_FLT] = 1'b1;
        end
        rate_next  = rate_reg;
        shift_next = shift_reg;
        if (reg_req_i.wr && reg_req_i.addr == OFS_PINS) begin
            rate_next = reg_req_i.wdata[CTL_RATE_BIT];
        end
        if (reg_req_i.wr && reg_req_i.addr == OFS_SHIFT) begin
            shift_next = reg_req_i.wdata;
        end
        case (reg_req_i.addr)
            OFS_CRIT_A:  rsel = flags_reg.crit_a;
            OFS_CRIT_B:  rsel = {flags_reg.crit_b, 6'h00};
            OFS_ADV_A:   rsel = flags_reg.adv_a;
            OFS_ADV_B:   rsel = {flags_reg.adv_b, 6'h00};
            OFS_SHIFT:   rsel = shift_reg;
            OFS_INDEX:   rsel = {2'h0, idx_reg};
            OFS_PINS:    rsel = {sync2_reg, 3'h0, rate_reg};
            OFS_HOUR_HI: rsel = password_ok_i ? {corrupt, hour_cnt[14:8]} : 8'h00;
            OFS_HOUR_LO: rsel = password_ok_i ? hour_cnt[7:0] : 8'h00;
            default: begin
                rsel = 8'h00;
                if (password_ok_i && reg_req_i.addr[7:3] == OFS_STORE[7:3]) begin
                    rsel = store_reg[reg_req_i.addr[2:0]];
                end
            end
        endcase
        rdata_next = reg_req_i.rd ? rsel : rdata_reg;
    end

    always_ff @(posedge clk_i) begin
        if (rrst) begin
            store_reg <= '0;
            load_reg  <= 1'b1;
            pre_reg   <= '0;
            nvw_reg   <= 1'b0;
            od_reg    <= OD_OFF;
            rate_reg  <= 1'b0;
            shift_reg <= SHIFT_RST;
            rdata_reg <= 8'h00;
        end else begin
            store_reg <= store_next;
            load_reg  <= 1'b0;
            pre_reg   <= pre_next;
            nvw_reg   <= nvw_next;
            od_reg    <= od_next;
            rate_reg  <= rate_next;
            shift_reg <= shift_next;
            rdata_reg <= rdata_next;
        end
    end

    assign od_out_o    = 3'h0;
    assign od_oe_n_o   = od_reg;
    assign nvm_image_o = store_reg;
    assign nvm_write_o = nvw_reg;
    assign reg_rdata_o = rdata_reg;

    // ==========================================================
    // Assertions.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    avg_sixteen_a: assert property (done_reg |-> $past(temp_valid_i)
        && $past(cnt_reg) == AVG_LAST) else $error("average without sixteen samples");
    index_top_a: assert property (!warm_reg && done_reg && idx_ok_reg
        && half > IDX_TOP && move |=> idx_reg == 6'h3F) else $error("index not clamped");
    index_hold_a: assert property (!warm_reg && done_reg && idx_ok_reg && !move
        |=> $stable(idx_reg)) else $error("index moved inside hysteresis");
    table_addr_a: assert property (!warm_reg ##1 !warm_reg |->
        addr_reg[2] == 8'h80 + {2'h0, $past(idx_reg)}) else $error("table address wrong");
    flag_set_a: assert property (!warm_reg && threshold_i.crit_a[7]
        && !cond_prev_reg.crit_a[7] |=> flags_reg.crit_a[7]) else $error("flag not set");
    flag_hold_a: assert property (!warm_reg && flags_reg.adv_b[1] && !txoff_fall
        && !(rd_hit && reg_req_i.addr == OFS_ADV_B) |=> flags_reg.adv_b[1])
        else $error("flag lost");
    txoff_clear_a: assert property (!warm_reg && txoff_fall && rise == 20'h00000
        |=> flags_reg == '0) else $error("flags not cleared");
    warm_reset_a: assert property (warm_reg |=> od_oe_n_o == OD_OFF
        && shift_reg == SHIFT_RST && idx_reg == 6'h00) else $error("warm reset incomplete");
    hour_step_a: assert property (!warm_reg && step && !st_wr && !load_reg
        |=> hour_cnt == $past(hour_inc)) else $error("hour count not stepped");
    hour_lock_a: assert property (reg_req_i.rd && !password_ok_i
        && reg_req_i.addr == OFS_HOUR_HI |=> reg_rdata_o == 8'h00)
        else $error("hour register read without password");
    txoff_clear_c: cover property (txoff_fall && flags_reg != '0);
    index_move_c:  cover property (done_reg && idx_ok_reg && move);
    hour_step_c:   cover property (step);
    warm_reset_c:  cover property (warm_reg);

endmodule // xcvr_monitor

// File: sim/od_pin_model.sv
`timescale 1ns/10ps
// ==========================================================
// Open-drain pins seen from the board: pull-up, own and outside drivers.
module od_pin_model (
    input  wire logic [2:0] od_oe_n_i,
    input  wire logic [2:0] od_out_i,
    input  wire logic [2:0] ext_pull_low_i,
    output logic [2:0]      pin_o
);
    // A pin is low when either party pulls it, otherwise the pull-up wins.
    assign pin_o = ~((~od_oe_n_i & ~od_out_i) | ext_pull_low_i);
endmodule // od_pin_model

// File: sim/xcvr_monitor_bench.sv
`timescale 1ns/10ps
module xcvr_monitor_bench;
    import xcvr_mon_pkg::*;
    localparam longint unsigned UNITS = 20;
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    reg_req_t         req = '0;
    logic [7:0]       rdata;
    logic             tvalid = 1'b0;
    logic signed [7:0] tsample = '0;
    quad_byte_t       entry = {4{8'hFB}};
    quad_byte_t       nominal = {4{8'h64}};
    quad_byte_t       taddr;
    quad_sum_t        setp;
    logic [5:0]       idx;
    logic             abort;
    threshold_t       thr = '0;
    logic             txoff = 1'b0;
    logic             loss_req = 1'b0;
    logic             flt_req = 1'b0;
    logic [2:0]       pins;
    logic [2:0]       od_out;
    logic [2:0]       oe_n;
    logic [2:0]       ext_low = 3'h0;
    logic             pw_ok = 1'b1;
    store_t           img_in = '0;
    store_t           img_out;
    logic             nvm_wr;
    int               fail_count = 0;
    int               num_checks = 0;
    int               cycles = 0;

    xcvr_monitor #(.UNIT_CYCLES(UNITS)) dut_u (
        .clk_i(clk), .rst_i(rst), .reg_req_i(req), .reg_rdata_o(rdata),
        .temp_valid_i(tvalid), .temp_sample_i(tsample), .table_entry_i(entry),
        .nominal_i(nominal), .table_addr_o(taddr), .setpoint_o(setp),
        .table_index_readback_o(idx), .conv_abort_o(abort), .threshold_i(thr),
        .transmit_off_input_i(txoff), .receive_loss_req_i(loss_req),
        .transmit_fault_req_i(flt_req), .od_pin_i(pins), .od_out_o(od_out),
        .od_oe_n_o(oe_n), .password_ok_i(pw_ok), .nvm_image_i(img_in),
        .nvm_image_o(img_out), .nvm_write_o(nvm_wr));

    od_pin_model pins_u (.od_oe_n_i(oe_n), .od_out_i(od_out),
        .ext_pull_low_i(ext_low), .pin_o(pins));

    // ==========================================================
    // Clock, watchdog and verdict.
    initial forever #2.5 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // Compare and register access tasks.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        req.addr = a;
        req.rd = 1'b1;
        @(negedge clk);
        req.rd = 1'b0;
        @(negedge clk);
        chk({8'h00, rdata}, {8'h00, e});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(negedge clk);
        req.wr = 1'b0;
    endtask

    task automatic wait_wr(output int n);
        n = 0;
        while (nvm_wr !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic temp_group(input logic signed [7:0] s, input logic [5:0] e);
        repeat (16) begin
            @(negedge clk);
            tvalid = 1'b1;
            tsample = s;
        end
        @(negedge clk);
        tvalid = 1'b0;
        repeat (5) @(negedge clk);
        chk({10'h000, idx}, {10'h000, e});
        for (int k = 0; k < 4; k++) begin
            chk({8'h00, taddr[k]}, {8'h00, TABLE_BASE[k] + {2'b00, e}});
            chk({7'h00, setp[k]}, 16'h005F);
        end
        rd_chk(OFS_INDEX, {2'b00, e});
    endtask

    // ==========================================================
    // Main sequence.
    initial begin
        logic [7:0] a;
        logic [7:0] b;
        int n;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        wait_wr(n);
        chk(16'(n >= 8 && n <= 12), 16'h0001);
        chk(img_out[15:0], 16'h8001);
        chk({13'h0000, od_out}, 16'h0000);
        @(negedge clk);
        wait_wr(n);
        chk(16'(n + 1), 16'(UNITS));
        rd_chk(OFS_HOUR_LO, 8'h02);
        rd_chk(OFS_HOUR_HI, 8'h00);
        pw_ok = 1'b0;
        rd_chk(OFS_HOUR_LO, 8'h00);
        rd_chk(OFS_HOUR_HI, 8'h00);
        pw_ok = 1'b1;
        chk({13'h0000, oe_n}, 16'h0007);
        for (int i = 0; i < 20; i++) begin
            @(negedge clk);
            thr = 20'(1) << i;
            @(negedge clk);
            thr = '0;
            if (i >= 12) begin a = OFS_CRIT_A; b = 8'h01 << (i - 12); end
            else if (i >= 10) begin a = OFS_CRIT_B; b = 8'h01 << (i - 4); end
            else if (i >= 2) begin a = OFS_ADV_A; b = 8'h01 << (i - 2); end
            else begin a = OFS_ADV_B; b = 8'h01 << (i + 6); end
            rd_chk(a, b);
            rd_chk(a, 8'h00);
        end
        txoff = 1'b1;
        repeat (4) @(negedge clk);
        thr = 20'h80000;
        @(negedge clk);
        thr = 20'h00A00;
        rd_chk(OFS_CRIT_A, 8'h80);
        thr = '0;
        txoff = 1'b0;
        repeat (6) @(negedge clk);
        rd_chk(OFS_ADV_A, 8'h00);
        rd_chk(OFS_CRIT_B, 8'h00);
        temp_group(8'sd40, 6'd20);
        temp_group(8'sd42, 6'd20);
        wr(OFS_SHIFT, 8'h04);
        temp_group(8'sd127, 6'd63);
        wr(OFS_SHIFT, 8'h00);
        temp_group(-8'sd40, 6'd0);
        rd_chk(OFS_PINS, 8'h70);
        loss_req = 1'b1;
        ext_low = 3'h2;
        repeat (4) @(negedge clk);
        rd_chk(OFS_PINS, 8'h40);
        chk({13'h0000, oe_n}, 16'h0006);
        loss_req = 1'b0;
        ext_low = 3'h0;
        wr(OFS_PINS, 8'h01);
        repeat (4) @(negedge clk);
        rd_chk(OFS_PINS, 8'h51);
        wr(OFS_SHIFT, 8'h05);
        flt_req = 1'b1;
        @(negedge clk);
        flt_req = 1'b0;
        repeat (2) @(negedge clk);
        chk({13'h0000, oe_n}, 16'h0001);
        img_in = 64'h0001_0001_0001_0001;
        wr(OFS_CFG, 8'h01);
        n = 0;
        while (abort !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        chk({15'h0000, abort}, 16'h0001);
        repeat (3) @(negedge clk);
        chk({13'h0000, oe_n}, 16'h0007);
        rd_chk(OFS_SHIFT, 8'h00);
        rd_chk(OFS_HOUR_HI, 8'h80);
        for (int k = 0; k < 8; k++) wr(OFS_STORE + 8'(k), 8'h00);
        repeat (2) @(negedge clk);
        rd_chk(OFS_HOUR_HI, 8'h00);
        chk(img_out[15:0], 16'h0000);
        report_and_stop();
    end
endmodule // xcvr_monitor_bench
